// file: hdl/ucpm_pkg.sv
package ucpm_pkg;
    // Register offsets on the byte-wide CPU register port
    localparam logic [7:0] CLOCK_STATUS_OFS = 8'h4A;
    localparam logic [7:0] CLOCK_GATE_CONTROL_OFS = 8'h4B;
    localparam logic [7:0] CLOCK_COMMAND_OFS = 8'h4D;
    // Reset values
    localparam logic [7:0] CLOCK_STATUS_RST = 8'h0F;
    localparam logic [7:0] CLOCK_GATE_CONTROL_RST = 8'h00;
    // Status field positions
    localparam int STAT_CORE_BIT = 3;
    localparam int STAT_PLL_OUT_BIT = 2;
    localparam int STAT_PLL_PWR_BIT = 1;
    localparam int STAT_OSC_BIT = 0;
    // Control field positions
    localparam int CTL_OSC_SEL_HI = 7;
    localparam int CTL_OSC_SEL_LO = 6;
    localparam int CTL_PLL_SEL_HI = 5;
    localparam int CTL_PLL_SEL_LO = 4;
    localparam int CTL_HOST_BIT = 3;
    localparam int CTL_PERIPH_BIT = 2;
    localparam int CTL_MAIN_BIT = 1;
    localparam int CTL_XCVR_BIT = 0;
    // Command codes
    localparam logic [7:0] CMD_OSC_WAKE = 8'h55;
    localparam logic [7:0] CMD_OSC_SLEEP = 8'hAA;
    localparam logic [7:0] CMD_PLL_WAKE = 8'h3C;
    localparam logic [7:0] CMD_PLL_SLEEP = 8'hC3;
    localparam logic [7:0] CMD_CORE_WAKE = 8'h69;
    localparam logic [7:0] CMD_CORE_SLEEP = 8'h96;
    // Clock rate and settle times in microseconds
    localparam int CLK_KHZ = 50000;
    localparam int OSC_T0_US = 2500;
    localparam int OSC_T1_US = 5000;
    localparam int OSC_T2_US = 10000;
    localparam int PLL_T0_US = 150;
    localparam int PLL_T1_US = 300;
    localparam int PLL_T2_US = 600;
    localparam int PLL_T3_US = 1200;
    // Settle counts in cycles (least times, round up)
    localparam int OSC_C0 = (OSC_T0_US * CLK_KHZ + 999) / 1000;
    localparam int OSC_C1 = (OSC_T1_US * CLK_KHZ + 999) / 1000;
    localparam int OSC_C2 = (OSC_T2_US * CLK_KHZ + 999) / 1000;
    localparam int PLL_C0 = (PLL_T0_US * CLK_KHZ + 999) / 1000;
    localparam int PLL_C1 = (PLL_T1_US * CLK_KHZ + 999) / 1000;
    localparam int PLL_C2 = (PLL_T2_US * CLK_KHZ + 999) / 1000;
    localparam int PLL_C3 = (PLL_T3_US * CLK_KHZ + 999) / 1000;
    localparam int CNT_W = 20;
    // Settle sequencer states
    typedef enum logic [1:0] {
        UCPM_IDLE = 2'b00,
        UCPM_OSC_WAIT = 2'b01,
        UCPM_PLL_WAIT = 2'b10
    } ucpm_state_t;
endpackage

// file: hdl/ucpm_settle_timer.sv
`timescale 1ns/10ps
// Down counter: load a cycle count, pulse done when it runs out
module ucpm_settle_timer
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [ucpm_pkg::CNT_W-1:0] count,
    output logic busy,
    output logic done
);
    // Remaining cycles
    logic [ucpm_pkg::CNT_W-1:0] cnt_q;
    logic busy_q;

    // Load wins over running down
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= '0;
            busy_q <= 1'b0;
        end
        else if (load)
        begin
            cnt_q <= count;
            busy_q <= 1'b1;
        end
        else if (busy_q)
        begin
            cnt_q <= cnt_q - 1'b1;
            busy_q <= (cnt_q > 1);
        end
    end

    assign busy = busy_q;
    // Last counting cycle; independent of load so a chained reload forms no loop
    assign done = busy_q && (cnt_q <= 1);
endmodule // ucpm_settle_timer

// file: hdl/ucpm_clock_power_manager.sv
// Notes on behaviour
// - Status resets to 0Fh, all clocks running
// - Status readable whatever the clock state
// - Core clocked bit returns after settle intervals
// - PLL output bit returns after settle intervals
// - PLL powered bit follows PLL commands immediately
// - Oscillator bit follows oscillator commands
// - Oscillator settle field selects 2.5/5/10 ms
// - Oscillator timer only after commanded sleep
// - PLL settle field selects 0.15 to 1.2 ms
// - PLL timer only after commanded sleep
// - Oscillator and PLL intervals chosen independently
// - Direct 48 MHz input bypasses settle timers
// - Control bit 3 gates host block
// - Control bit 2 gates peripheral block
// - Control bit 1 gates main blocks
// - Control bit 0 gates transceiver
// - Commands accepted whatever the clock state
// - 55h wakes, AAh sleeps the oscillator
// - 3Ch wakes, C3h sleeps the PLL
// - 69h wakes, 96h sleeps core blocks
// - PLL-only resume waits PLL interval only
`timescale 1ns/10ps
module ucpm_clock_power_manager
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic direct_48m_in,
    output logic oscillator_running,
    output logic pll_powered,
    output logic pll_output_delivered,
    output logic core_domain_clocked,
    output logic host_block_clk_en,
    output logic periph_block_clk_en,
    output logic main_block_clk_en,
    output logic transceiver_clk_en
);
    // Reset release synchroniser
    logic rst_s1_q;
    logic rst_n_q;
    // Strap pin synchroniser, three stages
    logic d48_s1_q;
    logic d48_s2_q;
    logic d48_s3_q;
    logic d48_q;
    // Control register fields
    logic [1:0] osc_settle_select_q;
    logic [1:0] pll_settle_select_q;
    logic host_block_gate_q;
    logic periph_block_gate_q;
    logic main_block_gate_q;
    logic transceiver_gate_q;
    // Clock state flags
    logic osc_q;
    logic pll_pwr_q;
    logic pll_out_q;
    logic core_q;
    // Request flags: which domains wait for settle
    logic pll_out_want_q;
    logic core_want_q;
    // Sequencer state
    ucpm_pkg::ucpm_state_t state_q;
    ucpm_pkg::ucpm_state_t state_d;
    // Read data register
    logic [7:0] rdata_q;
    // Timer hookup
    logic tmr_load;
    logic [ucpm_pkg::CNT_W-1:0] tmr_count;
    logic tmr_busy;
    logic tmr_done;

    // Oscillator settle count for a select code; 11b reserved, longest taken
    function automatic logic [ucpm_pkg::CNT_W-1:0] osc_cycles(input logic [1:0] sel);
        logic [ucpm_pkg::CNT_W-1:0] c;
        c = ucpm_pkg::CNT_W'(ucpm_pkg::OSC_C2);
        case (sel)
            2'b00: c = ucpm_pkg::CNT_W'(ucpm_pkg::OSC_C0);
            2'b01: c = ucpm_pkg::CNT_W'(ucpm_pkg::OSC_C1);
            default: c = ucpm_pkg::CNT_W'(ucpm_pkg::OSC_C2);
        endcase
        return c;
    endfunction

    // PLL settle count for a select code
    function automatic logic [ucpm_pkg::CNT_W-1:0] pll_cycles(input logic [1:0] sel);
        logic [ucpm_pkg::CNT_W-1:0] c;
        c = ucpm_pkg::CNT_W'(ucpm_pkg::PLL_C0);
        case (sel)
            2'b00: c = ucpm_pkg::CNT_W'(ucpm_pkg::PLL_C0);
            2'b01: c = ucpm_pkg::CNT_W'(ucpm_pkg::PLL_C1);
            2'b10: c = ucpm_pkg::CNT_W'(ucpm_pkg::PLL_C2);
            default: c = ucpm_pkg::CNT_W'(ucpm_pkg::PLL_C3);
        endcase
        return c;
    endfunction

    // Reset release through two flops
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // Pin synchroniser; the first stage feeds only the second
    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            d48_s1_q <= 1'b0;
            d48_s2_q <= 1'b0;
            d48_s3_q <= 1'b0;
            d48_q <= 1'b0;
        end
        else
        begin
            d48_s1_q <= direct_48m_in;
            d48_s2_q <= d48_s1_q;
            d48_s3_q <= d48_s2_q;
            // Only a settled level counts
            if (d48_s2_q == d48_s3_q)
            begin
                d48_q <= d48_s3_q;
            end
        end
    end

    // Register decode; writes need no running clock domain
    wire wr_ctl = reg_wr && (reg_addr == ucpm_pkg::CLOCK_GATE_CONTROL_OFS);
    wire wr_cmd = reg_wr && (reg_addr == ucpm_pkg::CLOCK_COMMAND_OFS);
    wire cmd_osc_wake = wr_cmd && (reg_wdata == ucpm_pkg::CMD_OSC_WAKE);
    wire cmd_osc_sleep = wr_cmd && (reg_wdata == ucpm_pkg::CMD_OSC_SLEEP);
    wire cmd_pll_wake = wr_cmd && (reg_wdata == ucpm_pkg::CMD_PLL_WAKE);
    wire cmd_pll_sleep = wr_cmd && (reg_wdata == ucpm_pkg::CMD_PLL_SLEEP);
    wire cmd_core_wake = wr_cmd && (reg_wdata == ucpm_pkg::CMD_CORE_WAKE);
    wire cmd_core_sleep = wr_cmd && (reg_wdata == ucpm_pkg::CMD_CORE_SLEEP);
    // any other byte decodes to nothing
    wire status_byte_hit = (reg_addr == ucpm_pkg::CLOCK_STATUS_OFS);
    wire ctl_byte_hit = (reg_addr == ucpm_pkg::CLOCK_GATE_CONTROL_OFS);
    // Anything waiting for a settle interval
    wire want_any = pll_out_want_q || core_want_q;

    // Control register; gating bits drive block enables directly
    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            osc_settle_select_q <= ucpm_pkg::CLOCK_GATE_CONTROL_RST[7:6];
            pll_settle_select_q <= ucpm_pkg::CLOCK_GATE_CONTROL_RST[5:4];
            host_block_gate_q <= ucpm_pkg::CLOCK_GATE_CONTROL_RST[3];
            periph_block_gate_q <= ucpm_pkg::CLOCK_GATE_CONTROL_RST[2];
            main_block_gate_q <= ucpm_pkg::CLOCK_GATE_CONTROL_RST[1];
            transceiver_gate_q <= ucpm_pkg::CLOCK_GATE_CONTROL_RST[0];
        end
        else if (wr_ctl)
        begin
            osc_settle_select_q <= reg_wdata[ucpm_pkg::CTL_OSC_SEL_HI:ucpm_pkg::CTL_OSC_SEL_LO];
            pll_settle_select_q <= reg_wdata[ucpm_pkg::CTL_PLL_SEL_HI:ucpm_pkg::CTL_PLL_SEL_LO];
            host_block_gate_q <= reg_wdata[ucpm_pkg::CTL_HOST_BIT];
            periph_block_gate_q <= reg_wdata[ucpm_pkg::CTL_PERIPH_BIT];
            main_block_gate_q <= reg_wdata[ucpm_pkg::CTL_MAIN_BIT];
            transceiver_gate_q <= reg_wdata[ucpm_pkg::CTL_XCVR_BIT];
        end
    end

    // Oscillator and PLL power flags
    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            osc_q <= ucpm_pkg::CLOCK_STATUS_RST[ucpm_pkg::STAT_OSC_BIT];
            pll_pwr_q <= ucpm_pkg::CLOCK_STATUS_RST[ucpm_pkg::STAT_PLL_PWR_BIT];
        end
        else
        begin
            if (cmd_osc_wake)
            begin
                osc_q <= 1'b1;
            end
            else if (cmd_osc_sleep)
            begin
                osc_q <= 1'b0;
            end
            if (cmd_pll_wake)
            begin
                pll_pwr_q <= 1'b1;
            end
            else if (cmd_pll_sleep)
            begin
                pll_pwr_q <= 1'b0;
            end
        end
    end

    // Settle sequencer: oscillator interval, then PLL interval
    always_comb
    begin
        state_d = state_q;
        tmr_load = 1'b0;
        tmr_count = '0;
        unique case (state_q)
            ucpm_pkg::UCPM_IDLE:
            begin
                // oscillator running means PLL wait only
                // PLL must be powered, else a stale wait could end early after its wake
                if (want_any && !d48_q && osc_q && pll_pwr_q && !tmr_busy)
                begin
                    state_d = ucpm_pkg::UCPM_PLL_WAIT;
                    tmr_load = 1'b1;
                    tmr_count = pll_cycles(pll_settle_select_q);
                end
            end
            ucpm_pkg::UCPM_OSC_WAIT:
            begin
                if (tmr_done)
                begin
                    state_d = ucpm_pkg::UCPM_PLL_WAIT;
                    tmr_load = 1'b1;
                    tmr_count = pll_cycles(pll_settle_select_q);
                end
            end
            ucpm_pkg::UCPM_PLL_WAIT:
            begin
                if (tmr_done)
                begin
                    state_d = ucpm_pkg::UCPM_IDLE;
                end
            end
            default:
            begin
                state_d = ucpm_pkg::UCPM_IDLE;
            end
        endcase
        // oscillator wake from commanded sleep starts the long wait
        if (cmd_osc_wake && !osc_q && !d48_q)
        begin
            state_d = ucpm_pkg::UCPM_OSC_WAIT;
            tmr_load = 1'b1;
            tmr_count = osc_cycles(osc_settle_select_q);
        end
        if (d48_q)
        begin
            state_d = ucpm_pkg::UCPM_IDLE;
        end
    end

    // Timer shared by both settle phases
    ucpm_settle_timer u_timer
    (
        .clk(clk),
        .rst_n(rst_n_q),
        .load(tmr_load),
        .count(tmr_count),
        .busy(tmr_busy),
        .done(tmr_done)
    );

    // Phase is complete when PLL wait ends or the bypass is active
    // Oscillator slept mid-wait: no grant; a core request waits for a fresh sequence, a PLL output request is dropped
    wire settle_end = (state_q == ucpm_pkg::UCPM_PLL_WAIT) && tmr_done && osc_q;
    wire grant = settle_end || (d48_q && want_any);

    // Sequencer state and clock delivery flags
    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            state_q <= ucpm_pkg::UCPM_IDLE;
            pll_out_q <= ucpm_pkg::CLOCK_STATUS_RST[ucpm_pkg::STAT_PLL_OUT_BIT];
            core_q <= ucpm_pkg::CLOCK_STATUS_RST[ucpm_pkg::STAT_CORE_BIT];
            pll_out_want_q <= 1'b0;
            core_want_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            if (cmd_pll_sleep || cmd_osc_sleep)
            begin
                pll_out_q <= 1'b0;
                pll_out_want_q <= 1'b0;
            end
            else if (cmd_pll_wake && !pll_out_q)
            begin
                pll_out_want_q <= 1'b1;
            end
            else if (grant && pll_out_want_q && pll_pwr_q)
            begin
                pll_out_q <= 1'b1;
                pll_out_want_q <= 1'b0;
            end
            if (cmd_core_sleep || cmd_osc_sleep || cmd_pll_sleep)
            begin
                core_q <= 1'b0;
                core_want_q <= cmd_core_sleep ? 1'b0 : core_want_q;
            end
            else if (cmd_core_wake && !core_q)
            begin
                core_want_q <= 1'b1;
            end
            else if (grant && core_want_q && pll_pwr_q)
            begin
                core_q <= 1'b1;
                core_want_q <= 1'b0;
            end
        end
    end

    // Status byte, reserved bits zero
    wire [7:0] status_byte = {4'h0, core_q, pll_out_q, pll_pwr_q, osc_q};
    wire [7:0] ctl_byte = {osc_settle_select_q, pll_settle_select_q, host_block_gate_q,
        periph_block_gate_q, main_block_gate_q, transceiver_gate_q};

    // Read data register; command register reads as zero
    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            rdata_q <= 8'h00;
        end
        else if (reg_rd)
        begin
            if (status_byte_hit)
            begin
                rdata_q <= status_byte;
            end
            else if (ctl_byte_hit)
            begin
                rdata_q <= ctl_byte;
            end
            else
            begin
                rdata_q <= 8'h00;
            end
        end
    end

    assign reg_rdata = rdata_q;
    assign oscillator_running = osc_q;
    assign pll_powered = pll_pwr_q;
    assign pll_output_delivered = pll_out_q;
    assign core_domain_clocked = core_q;
    assign host_block_clk_en = !host_block_gate_q;
    assign periph_block_clk_en = !periph_block_gate_q;
    assign main_block_clk_en = !main_block_gate_q;
    assign transceiver_clk_en = !transceiver_gate_q;
endmodule // ucpm_clock_power_manager

// file: tb/ucpm_clock_power_manager_properties.sv
`timescale 1ns/10ps
module ucpm_clock_power_manager_properties
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic direct_48m_in,
    input wire logic oscillator_running,
    input wire logic pll_powered,
    input wire logic pll_output_delivered,
    input wire logic core_domain_clocked,
    input wire logic host_block_clk_en,
    input wire logic periph_block_clk_en,
    input wire logic main_block_clk_en,
    input wire logic transceiver_clk_en
);
    // Status flags packed as they appear in the status register
    logic [3:0] stat_w;
    // Clock enables in control bit order
    logic [3:0] gate_w;
    // High when the written byte is one of the six commands
    logic known_w;
    assign stat_w = {core_domain_clocked, pll_output_delivered, pll_powered, oscillator_running};
    assign gate_w = {host_block_clk_en, periph_block_clk_en, main_block_clk_en, transceiver_clk_en};
    assign known_w = reg_wdata inside {8'h55, 8'hAA, 8'h3C, 8'hC3, 8'h69, 8'h96};

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    // One command byte taken at this edge
    sequence s_cmd(logic [7:0] code);
        reg_wr && reg_addr == ucpm_pkg::CLOCK_COMMAND_OFS && reg_wdata == code;
    endsequence
    // PLL wake while the timers are in use and output is down
    sequence s_slow_wake;
        s_cmd(ucpm_pkg::CMD_PLL_WAKE) ##0 (!pll_output_delivered && !direct_48m_in);
    endsequence

    a_gate_follow : assert property (
        reg_wr && reg_addr == ucpm_pkg::CLOCK_GATE_CONTROL_OFS
        |=> gate_w == ~$past(reg_wdata[3:0])) else $error("clock enable mismatch after write");
    a_pll_sleep : assert property (
        s_cmd(ucpm_pkg::CMD_PLL_SLEEP) |=> !pll_powered && !pll_output_delivered)
        else $error("PLL sleep not applied");
    a_pll_power : assert property (
        s_cmd(ucpm_pkg::CMD_PLL_WAKE) |=> pll_powered) else $error("PLL power not restored");
    a_osc_sleep : assert property (
        s_cmd(ucpm_pkg::CMD_OSC_SLEEP) |=> !oscillator_running && !pll_output_delivered)
        else $error("oscillator sleep not applied");
    a_osc_wake : assert property (
        s_cmd(ucpm_pkg::CMD_OSC_WAKE) |=> oscillator_running) else $error("oscillator not woken");
    a_pll_waits : assert property (
        s_slow_wake |=> !pll_output_delivered [*8]) else $error("PLL output came back early");
    a_out_needs_pwr : assert property (
        pll_output_delivered |-> pll_powered && oscillator_running)
        else $error("PLL output without PLL power");
    a_unknown_cmd : assert property (
        reg_wr && reg_addr == ucpm_pkg::CLOCK_COMMAND_OFS && !known_w && !pll_powered
        |=> $stable(stat_w)) else $error("unknown command changed status");
    a_status_read : assert property (
        reg_rd && reg_addr == ucpm_pkg::CLOCK_STATUS_OFS
        |=> reg_rdata == {4'h0, $past(stat_w)}) else $error("status read mismatch");
endmodule // ucpm_clock_power_manager_properties

// file: tb/ucpm_clock_power_manager_tb.sv
`timescale 1ns/10ps
`define CHK(nm, exp, got) \
    n_tests++; \
    if ((got) !== (exp)) \
    begin \
        errors++; \
        $display("unexpected %s exp %h got %h", nm, exp, got); \
    end
module ucpm_clock_power_manager_tb;
    logic clk, arst_n, reg_wr, reg_rd, direct_48m_in;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
    logic osc, pll_pwr, pll_out, core, host_en, periph_en, main_en, xcvr_en;
    int errors = 0;
    int n_tests = 0;
    // Status flags and enables grouped for compact checks
    wire [3:0] stat = {core, pll_out, pll_pwr, osc};
    wire [3:0] gates = {host_en, periph_en, main_en, xcvr_en};

    ucpm_clock_power_manager u_dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .direct_48m_in(direct_48m_in), .oscillator_running(osc), .pll_powered(pll_pwr),
        .pll_output_delivered(pll_out), .core_domain_clocked(core), .host_block_clk_en(host_en),
        .periph_block_clk_en(periph_en), .main_block_clk_en(main_en),
        .transceiver_clk_en(xcvr_en));

    // 50 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // One write strobe; leaves an idle edge before the next access
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // One read strobe; data is registered at the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Status bit must be low after lo cycles, then rise within win more
    task automatic settle(input int idx, input int lo, input int win);
        int k;
        repeat (lo) @(posedge clk);
        #1;
        `CHK("settle early", 1'b0, stat[idx])
        for (k = 0; k < win && stat[idx] !== 1'b1; k++)
        begin
            @(posedge clk);
            #1;
        end
        `CHK("settle late", 1'b1, stat[idx])
    endtask

    // Values straight out of reset, and the non-storing addresses
    task automatic t_reset;
        `CHK("status flags", 4'hF, stat)
        `CHK("enables", 4'hF, gates)
        rd(ucpm_pkg::CLOCK_STATUS_OFS, rv);
        `CHK("status reg", ucpm_pkg::CLOCK_STATUS_RST, rv)
        rd(ucpm_pkg::CLOCK_GATE_CONTROL_OFS, rv);
        `CHK("control reg", ucpm_pkg::CLOCK_GATE_CONTROL_RST, rv)
        rd(ucpm_pkg::CLOCK_COMMAND_OFS, rv);
        `CHK("command reg", 8'h00, rv)
        rd(8'h4C, rv);
        `CHK("unmapped reg", 8'h00, rv)
    endtask

    // Each gate bit alone stops exactly its own block
    task automatic t_gates;
        int i;
        for (i = 0; i < 4; i++)
        begin
            wr(ucpm_pkg::CLOCK_GATE_CONTROL_OFS, 8'h01 << i);
            `CHK("enables", ~(4'h1 << i), gates)
            rd(ucpm_pkg::CLOCK_GATE_CONTROL_OFS, rv);
            `CHK("control back", 8'h01 << i, rv)
        end
        wr(ucpm_pkg::CLOCK_GATE_CONTROL_OFS, 8'h00);
        `CHK("enables", 4'hF, gates)
    endtask

    // PLL alone slept and resumed; only the PLL interval is waited
    task automatic t_pll;
        // Oscillator field at the longest code, PLL field at 01b
        wr(ucpm_pkg::CLOCK_GATE_CONTROL_OFS, 8'h90);
        rd(ucpm_pkg::CLOCK_GATE_CONTROL_OFS, rv);
        `CHK("control back", 8'h90, rv)
        wr(ucpm_pkg::CLOCK_COMMAND_OFS, ucpm_pkg::CMD_PLL_SLEEP);
        `CHK("after sleep", 4'h1, stat)
        wr(ucpm_pkg::CLOCK_COMMAND_OFS, 8'h00);
        wr(ucpm_pkg::CLOCK_COMMAND_OFS, 8'hFF);
        rd(ucpm_pkg::CLOCK_STATUS_OFS, rv);
        `CHK("status asleep", 8'h01, rv)
        wr(ucpm_pkg::CLOCK_COMMAND_OFS, ucpm_pkg::CMD_PLL_WAKE);
        `CHK("pll power", 1'b1, pll_pwr)
        settle(2, ucpm_pkg::PLL_C1 - 4, 20);
        `CHK("core still off", 1'b0, core)
        wr(ucpm_pkg::CLOCK_GATE_CONTROL_OFS, 8'h00);
        wr(ucpm_pkg::CLOCK_COMMAND_OFS, ucpm_pkg::CMD_CORE_WAKE);
        settle(3, ucpm_pkg::PLL_C0 - 4, 20);
        wr(ucpm_pkg::CLOCK_COMMAND_OFS, ucpm_pkg::CMD_CORE_SLEEP);
        `CHK("core sleep", 4'h7, stat)
    endtask

    // Direct 48 MHz feed: no settle wait, gating still works
    task automatic t_direct;
        @(posedge clk);
        direct_48m_in <= 1'b1;
        repeat (6) @(posedge clk);
        wr(ucpm_pkg::CLOCK_COMMAND_OFS, ucpm_pkg::CMD_OSC_SLEEP);
        `CHK("osc sleep", 1'b0, osc)
        `CHK("core off", 1'b0, core)
        wr(ucpm_pkg::CLOCK_COMMAND_OFS, ucpm_pkg::CMD_OSC_WAKE);
        wr(ucpm_pkg::CLOCK_COMMAND_OFS, ucpm_pkg::CMD_PLL_WAKE);
        wr(ucpm_pkg::CLOCK_COMMAND_OFS, ucpm_pkg::CMD_CORE_WAKE);
        repeat (20) @(posedge clk);
        rd(ucpm_pkg::CLOCK_STATUS_OFS, rv);
        `CHK("status bypass", 8'h0F, rv)
        wr(ucpm_pkg::CLOCK_GATE_CONTROL_OFS, 8'h08);
        `CHK("enables bypass", 4'h7, gates)
    endtask

    // Verdict and end of run
    task automatic give_verdict;
        if (errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Watchdog: the tests need about 23000 cycles
    initial
    begin
        repeat (40000) @(posedge clk);
        errors++;
        give_verdict();
    end

    // Main sequence
    initial
    begin
        arst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        direct_48m_in = 1'b0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        t_reset();
        t_gates();
        t_pll();
        t_direct();
        give_verdict();
    end
endmodule // ucpm_clock_power_manager_tb

bind ucpm_clock_power_manager ucpm_clock_power_manager_properties u_props (.clk(clk),
    .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .direct_48m_in(direct_48m_in),
    .oscillator_running(oscillator_running), .pll_powered(pll_powered),
    .pll_output_delivered(pll_output_delivered), .core_domain_clocked(core_domain_clocked),
    .host_block_clk_en(host_block_clk_en), .periph_block_clk_en(periph_block_clk_en),
    .main_block_clk_en(main_block_clk_en), .transceiver_clk_en(transceiver_clk_en));
